/* hw/shift_and_extend_datapath.sv */
// Function
// RULE_01: Zero shift length passes source through and keeps carry.
// RULE_02: Nonzero shifts write the result and update carry when flagged.
// RULE_03: Arithmetic right shift fills top n bits with bit 31.
// RULE_04: Flagged arithmetic right shift takes carry from bit n-1.
// RULE_05: Arithmetic right of 32 or more gives all bit 31, carry bit 31.
// RULE_06: Logical right shift fills top n bits with zero.
// RULE_07: Flagged logical right shift takes carry from bit n-1.
// RULE_08: Logical right of 32+ gives zero; 33+ gives zero carry.
// RULE_09: Link register value written by branch-link has bit 0 forced one.
// RULE_10: Branch targets loaded into the program counter carry bit 0 set.
// RULE_11: Sign and zero extend low byte or halfword, flags unchanged.
// RULE_12: Store data is full word, low halfword or low byte.
// RULE_13: AND test discards result, updates only negative and zero.
// RULE_14: Left shift zero-fills; carry bit 32-n; 32+ zero; 33+ zero carry.
// RULE_15: Rotate right wraps low bits; 32 keeps value, carry bit 31.
// RULE_16: Shift length is an unsigned 8-bit value up to 255.
module shift_and_extend_datapath
	import sed_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Async reset, active low
	input wire logic op_valid, // Operation request this cycle
	input wire sed_op_e op_code, // Operation select
	input wire logic [SED_W-1:0] operand_a, // Shift source operand
	input wire logic [SED_W-1:0] operand_b, // Second operand for test
	input wire logic [7:0] shift_len, // Unsigned shift length
	input wire logic set_flags, // Flag-setting variant
	output logic [SED_W-1:0] result, // Result to destination
	output logic result_we, // Destination write enable pulse
	output logic [SED_W-1:0] store_data, // Store write data
	output logic store_valid, // Store data valid pulse
	output logic flag_n, // Negative flag
	output logic flag_z, // Zero flag
	output logic flag_c, // Carry flag
	output logic target_bad, // Branch target lacks bit 0
	output logic done // Operation completed pulse
);

	// ***************************************************************
	// Registers
	// ***************************************************************
	logic [SED_W-1:0] result_reg, result_next;
	logic result_we_reg, result_we_next;
	logic [SED_W-1:0] store_data_reg, store_data_next;
	logic store_valid_reg, store_valid_next;
	logic flag_n_reg, flag_n_next;
	logic flag_z_reg, flag_z_next;
	logic flag_c_reg, flag_c_next;
	logic target_bad_reg, target_bad_next;
	sed_state_e state_reg, state_next;
	logic [SED_W-1:0] sh_res;
	logic sh_carry;

	// Sign or zero extension of a low field
	function automatic logic [SED_W-1:0] extend(
		input logic [SED_W-1:0] v,
		input int unsigned msb,
		input logic signed_ext
	);
		logic [SED_W-1:0] o;
		o = '0;
		for (int i = 0; i < SED_W; i++) begin
			if (i <= msb) begin
				o[i] = v[i];
			end else begin
				o[i] = signed_ext & v[msb];
			end
		end
		return o;
	endfunction

	// Is the operation one of the shifts
	function automatic logic is_shift(input sed_op_e o);
		return (o == SED_OP_ASHR) || (o == SED_OP_LSHR) ||
			(o == SED_OP_LSHL) || (o == SED_OP_ROTR);
	endfunction

	// ***************************************************************
	// Shifter
	// ***************************************************************
	sed_shifter u_shifter (
		.src(operand_a),
		.len(shift_len), // [RULE_16]
		.op(op_code),
		.carry_in(flag_c_reg),
		.res(sh_res),
		.carry_out(sh_carry)
	);

	// ***************************************************************
	// Next-state logic
	// ***************************************************************
	always_comb begin
		logic [SED_W-1:0] t;
		t = operand_a & operand_b;
		result_next = result_reg;
		result_we_next = 1'b0;
		store_data_next = store_data_reg;
		store_valid_next = 1'b0;
		flag_n_next = flag_n_reg;
		flag_z_next = flag_z_reg;
		flag_c_next = flag_c_reg;
		target_bad_next = 1'b0;
		state_next = SED_ST_IDLE;
		if (op_valid) begin
			state_next = SED_ST_DONE;
			unique case (op_code)
				SED_OP_PASS: begin
					result_next = operand_a;
					result_we_next = 1'b1;
				end
				SED_OP_ASHR, SED_OP_LSHR, SED_OP_LSHL, SED_OP_ROTR: begin
					result_next = sh_res; // [RULE_02]
					result_we_next = 1'b1;
					if (set_flags && is_shift(op_code)) begin
						flag_c_next = sh_carry; // [RULE_01] [RULE_02]
						flag_n_next = sh_res[SED_SIGN_BIT];
						flag_z_next = (sh_res == '0);
					end
				end
				SED_OP_SXB: begin
					result_next = extend(operand_a, SED_BYTE_MSB, 1'b1); // [RULE_11]
					result_we_next = 1'b1;
				end
				SED_OP_SXH: begin
					result_next = extend(operand_a, SED_HALF_MSB, 1'b1); // [RULE_11]
					result_we_next = 1'b1;
				end
				SED_OP_UXB: begin
					result_next = extend(operand_a, SED_BYTE_MSB, 1'b0); // [RULE_11]
					result_we_next = 1'b1;
				end
				SED_OP_UXH: begin
					result_next = extend(operand_a, SED_HALF_MSB, 1'b0); // [RULE_11]
					result_we_next = 1'b1;
				end
				SED_OP_STW: begin
					store_data_next = operand_a; // [RULE_12]
					store_valid_next = 1'b1;
				end
				SED_OP_STH: begin
					store_data_next = extend(operand_a, SED_HALF_MSB, 1'b0); // [RULE_12]
					store_valid_next = 1'b1;
				end
				SED_OP_STB: begin
					store_data_next = extend(operand_a, SED_BYTE_MSB, 1'b0); // [RULE_12]
					store_valid_next = 1'b1;
				end
				SED_OP_ANDT: begin
					flag_n_next = t[SED_SIGN_BIT]; // [RULE_13]
					flag_z_next = (t == '0); // [RULE_13]
				end
				SED_OP_LNK: begin
					result_next = operand_a;
					result_next[SED_STATE_BIT] = 1'b1; // [RULE_09]
					result_we_next = 1'b1;
				end
				SED_OP_BRT: begin
					result_next = operand_a;
					result_we_next = 1'b1;
					// Flags a target without the state bit [RULE_10]
					target_bad_next = ~operand_a[SED_STATE_BIT];
				end
				default: begin
					state_next = SED_ST_IDLE;
				end
			endcase
		end
	end

	// ***************************************************************
	// State registers
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= '0;
			result_we_reg <= 1'b0;
			store_data_reg <= '0;
			store_valid_reg <= 1'b0;
			flag_n_reg <= 1'b0;
			flag_z_reg <= 1'b0;
			flag_c_reg <= 1'b0;
			target_bad_reg <= 1'b0;
			state_reg <= SED_ST_IDLE;
		end else begin
			result_reg <= result_next;
			result_we_reg <= result_we_next;
			store_data_reg <= store_data_next;
			store_valid_reg <= store_valid_next;
			flag_n_reg <= flag_n_next;
			flag_z_reg <= flag_z_next;
			flag_c_reg <= flag_c_next;
			target_bad_reg <= target_bad_next;
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign result = result_reg;
	assign result_we = result_we_reg;
	assign store_data = store_data_reg;
	assign store_valid = store_valid_reg;
	assign flag_n = flag_n_reg;
	assign flag_z = flag_z_reg;
	assign flag_c = flag_c_reg;
	assign target_bad = target_bad_reg;
	assign done = state_reg[1]; // One-hot done bit of the state flop

endmodule // shift_and_extend_datapath

/* hw/sed_pkg.sv */
package sed_pkg;

	// ***************************************************************
	// Widths
	// ***************************************************************
	localparam int unsigned SED_W = 32;
	localparam logic [7:0] SED_LEN_ZERO = 8'h00;
	localparam logic [7:0] SED_LEN_WORD = 8'h20;
	localparam logic [7:0] SED_LEN_WORD_P1 = 8'h21;
	localparam int unsigned SED_SIGN_BIT = 31;
	localparam int unsigned SED_STATE_BIT = 0;
	localparam int unsigned SED_BYTE_MSB = 7;
	localparam int unsigned SED_HALF_MSB = 15;
	localparam logic [4:0] SED_ROT_MASK = 5'h1f;

	// ***************************************************************
	// Operation codes
	// ***************************************************************
	typedef enum logic [3:0] {
		SED_OP_PASS = 4'h0,
		SED_OP_ASHR = 4'h1,
		SED_OP_LSHR = 4'h2,
		SED_OP_LSHL = 4'h3,
		SED_OP_ROTR = 4'h4,
		SED_OP_SXB = 4'h5,
		SED_OP_SXH = 4'h6,
		SED_OP_UXB = 4'h7,
		SED_OP_UXH = 4'h8,
		SED_OP_STW = 4'h9,
		SED_OP_STH = 4'ha,
		SED_OP_STB = 4'hb,
		SED_OP_ANDT = 4'hc,
		SED_OP_LNK = 4'hd,
		SED_OP_BRT = 4'he
	} sed_op_e;

	// Unit state
	typedef enum logic [1:0] {
		SED_ST_IDLE = 2'b01,
		SED_ST_DONE = 2'b10
	} sed_state_e;

endpackage : sed_pkg

/* hw/sed_shifter.sv */
// Combinational barrel shifter with carry-out
module sed_shifter
	import sed_pkg::*;
(
	input wire logic [SED_W-1:0] src, // Shift source operand
	input wire logic [7:0] len, // Unsigned shift length
	input wire sed_op_e op, // Shift kind
	input wire logic carry_in, // Current carry flag
	output logic [SED_W-1:0] res, // Shift result
	output logic carry_out // Carry after shift
);

	// ***************************************************************
	// Shift network
	// ***************************************************************
	always_comb begin
		logic [SED_W-1:0] sgn;
		logic [2*SED_W-1:0] dbl;
		logic [4:0] r;
		sgn = {SED_W{src[SED_SIGN_BIT]}};
		dbl = {src, src};
		r = len[4:0] & SED_ROT_MASK;
		res = src;
		carry_out = carry_in;
		if (len != SED_LEN_ZERO) begin // [RULE_01] [RULE_02]
			unique case (op)
				SED_OP_ASHR: begin
					if (len >= SED_LEN_WORD) begin // [RULE_05]
						res = sgn;
						carry_out = src[SED_SIGN_BIT];
					end else begin
						res = SED_W'($signed(src) >>> len[4:0]); // [RULE_03]
						carry_out = src[len[4:0] - 5'h1]; // [RULE_04]
					end
				end
				SED_OP_LSHR: begin
					if (len >= SED_LEN_WORD) begin // [RULE_08]
						res = '0;
						carry_out = (len == SED_LEN_WORD) ?
							src[SED_SIGN_BIT] : 1'b0;
					end else begin
						res = src >> len[4:0]; // [RULE_06]
						carry_out = src[len[4:0] - 5'h1]; // [RULE_07]
					end
				end
				SED_OP_LSHL: begin
					if (len >= SED_LEN_WORD) begin // [RULE_14]
						res = '0;
						carry_out = (len == SED_LEN_WORD) ? src[0] : 1'b0;
					end else begin
						res = src << len[4:0]; // [RULE_14]
						carry_out = src[5'(SED_W) - len[4:0]];
					end
				end
				SED_OP_ROTR: begin
					if (r == 5'h0) begin // [RULE_15]
						res = src;
						carry_out = src[SED_SIGN_BIT];
					end else begin
						res = dbl[r +: SED_W]; // [RULE_15]
						carry_out = src[r - 5'h1];
					end
				end
				default: begin
					res = src;
					carry_out = carry_in;
				end
			endcase
		end
	end

endmodule // sed_shifter

/* verification/shift_and_extend_datapath_props.sv */
// Port-level checks of the shift and extend datapath
module sed_props
	import sed_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic op_valid, // Request
	input wire sed_op_e op_code, // Operation
	input wire logic [SED_W-1:0] operand_a, // Source
	input wire logic [SED_W-1:0] operand_b, // Test operand
	input wire logic [7:0] shift_len, // Shift length
	input wire logic set_flags, // Flag variant
	input wire logic [SED_W-1:0] result, // Result
	input wire logic result_we, // Result write
	input wire logic [SED_W-1:0] store_data, // Store data
	input wire logic store_valid, // Store pulse
	input wire logic flag_z, // Zero flag
	input wire logic flag_c, // Carry flag
	input wire logic done // Done pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Request of one kind
	sequence s_op(sed_op_e o);
		op_valid && op_code == o;
	endsequence
	// Any shift request
	sequence s_sh;
		op_valid && op_code inside {[SED_OP_ASHR:SED_OP_ROTR]};
	endsequence
	a_op_done: assert property (op_valid && op_code != 4'hf |=> done)
		else $error("done missing");
	a_zero_pass: assert property (s_sh ##0 shift_len == SED_LEN_ZERO |=>
		result == $past(operand_a) && flag_c == $past(flag_c))
		else $error("zero shift altered value");
	a_asr_wide: assert property (s_op(SED_OP_ASHR) ##0
		shift_len >= SED_LEN_WORD
		|=> result == {32{$past(operand_a[31])}}) else $error("wide asr");
	a_lsr_wide: assert property (s_op(SED_OP_LSHR) ##0
		shift_len >= SED_LEN_WORD
		|=> result == '0 && result_we) else $error("wide lsr");
	a_link_bit: assert property (s_op(SED_OP_LNK) |=> result_we && result[0])
		else $error("link bit low");
	a_ext_flags: assert property (op_valid &&
		op_code inside {[SED_OP_SXB:SED_OP_UXH]} |=> $stable({flag_z, flag_c}))
		else $error("extend touched flags");
	a_store_byte: assert property (s_op(SED_OP_STB) |=> store_valid &&
		store_data == ($past(operand_a) & 32'h0000_00ff)) else $error("byte store");
	a_tst_flags: assert property (s_op(SED_OP_ANDT) |=>
		$stable(flag_c) &&
		flag_z == (($past(operand_a) & $past(operand_b)) == '0))
		else $error("test flags");
	a_noflag_c: assert property (s_sh ##0 !set_flags |=> $stable(flag_c))
		else $error("carry moved");
endmodule // sed_props

bind shift_and_extend_datapath sed_props sed_props_inst (.clk, .rst_n,
	.op_valid, .op_code, .operand_a, .operand_b, .shift_len, .set_flags,
	.result, .result_we, .store_data, .store_valid, .flag_z, .flag_c, .done);

/* verification/shift_and_extend_datapath_bench.sv */
module shift_and_extend_datapath_bench;
	import sed_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, op_valid, set_flags, result_we, store_valid, done;
	logic flag_n, flag_z, flag_c, target_bad, en, ez, ec;
	sed_op_e op_code;
	logic [31:0] operand_a, operand_b, result, store_data;
	logic [7:0] shift_len;
	int err_count, checks_done;
	shift_and_extend_datapath shift_and_extend_datapath_inst (.clk, .rst_n,
		.op_valid, .op_code, .operand_a, .operand_b, .shift_len, .set_flags,
		.result, .result_we, .store_data, .store_valid, .flag_n, .flag_z,
		.flag_c, .target_bad, .done);
	// Clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ********
	// Helpers
	// ********
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// Present one request at a falling edge, return after its answer
	task automatic run(sed_op_e o, logic [31:0] a, b, logic [7:0] n, logic f);
		op_valid = 1'b1;
		op_code = o;
		operand_a = a;
		operand_b = b;
		shift_len = n;
		set_flags = f;
		@(negedge clk);
		chk("done", 32'(o != 4'hf), done);
	endtask
	task automatic flags();
		chk("flags", {en, ez, ec}, {flag_n, flag_z, flag_c});
	endtask
	// Expected {result, carry}
	function automatic logic [32:0] model(sed_op_e o, logic [31:0] a,
		logic [7:0] n, logic c);
		logic [32:0] t;
		logic [31:0] r;
		if (n == 8'h00) return {a, c};
		case (o)
			SED_OP_ASHR: t = $signed({a, 1'b0}) >>> n;
			SED_OP_LSHR: t = {a, 1'b0} >> n;
			SED_OP_LSHL: begin
				t = {1'b0, a} << n;
				t = {t[31:0], t[32]};
			end
			default: begin
				r = (a >> n[4:0]) | (a << (32 - n[4:0]));
				t = {r, r[31]};
			end
		endcase
		return t;
	endfunction
	// ********
	// Scenarios
	// ********
	task automatic t_shifts();
		sed_op_e ops[4] = '{SED_OP_ASHR, SED_OP_LSHR, SED_OP_LSHL,
			SED_OP_ROTR};
		logic [7:0] ln[9] = '{8'h01, 8'h04, 8'h00, 8'h1f, 8'h20, 8'h21,
			8'h40, 8'h41, 8'hff};
		logic [32:0] m;
		foreach (ops[i]) foreach (ln[j]) begin
			m = model(ops[i], 32'h9000_0009, ln[j], ec);
			run(ops[i], 32'h9000_0009, '0, ln[j], 1'b1);
			{en, ez, ec} = {m[32], m[32:1] == '0, m[0]};
			chk("shift", m[32:1], result);
			flags();
			if (ln[j] != 8'h00) chk("we", 1, result_we);
		end
		$display("test shifts finished");
	endtask
	task automatic t_extend();
		sed_op_e ops[4] = '{SED_OP_SXB, SED_OP_SXH, SED_OP_UXB, SED_OP_UXH};
		logic [31:0] ex[4] = '{32'hffff_ff85, 32'hffff_8085, 32'h0000_0085,
			32'h0000_8085};
		foreach (ops[i]) begin
			run(ops[i], 32'h1234_8085, '0, 8'h00, 1'b1);
			chk("extend", ex[i], result);
			flags();
		end
		$display("test extend finished");
	endtask
	task automatic t_store();
		sed_op_e ops[3] = '{SED_OP_STW, SED_OP_STH, SED_OP_STB};
		logic [31:0] ex[3] = '{32'hab12_cd34, 32'h0000_cd34, 32'h0000_0034};
		foreach (ops[i]) begin
			run(ops[i], 32'hab12_cd34, '0, 8'h00, 1'b0);
			chk("store", {ex[i], 1'b1}, {store_data, store_valid});
		end
		$display("test store finished");
	endtask
	task automatic t_test();
		run(SED_OP_ANDT, 32'h0000_f0f0, 32'h0000_0f0f, 8'h00, 1'b1);
		{en, ez} = 2'b01;
		flags();
		run(SED_OP_ANDT, 32'h8000_0000, 32'hffff_ffff, 8'h00, 1'b1);
		{en, ez} = 2'b10;
		flags();
		$display("test and finished");
	endtask
	task automatic t_branch();
		run(SED_OP_LNK, 32'h0000_1000, '0, 8'h00, 1'b0);
		chk("link", 32'h0000_1001, result);
		run(SED_OP_BRT, 32'h0000_2000, '0, 8'h00, 1'b0);
		chk("bad", 1, target_bad);
		run(SED_OP_BRT, 32'h0000_2001, '0, 8'h00, 1'b0);
		chk("bad", 0, target_bad);
		$display("test branch finished");
	endtask
	task automatic t_refused();
		run(sed_op_e'(4'hf), 32'h5, '0, 8'h01, 1'b1);
		chk("we", 0, result_we);
		run(SED_OP_ROTR, 32'h0000_0010, '0, 8'h04, 1'b0);
		chk("ror", 32'h0000_0001, result);
		flags();
		$display("test refused finished");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
	// Main sequence
	initial begin
		{rst_n, op_valid, set_flags, en, ez, ec} = '0;
		{operand_a, operand_b, shift_len} = '0;
		op_code = SED_OP_PASS;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_shifts();
		t_extend();
		t_store();
		t_test();
		t_branch();
		t_refused();
		op_valid = 1'b0;
		@(negedge clk);
		finish_test();
	end
endmodule // shift_and_extend_datapath_bench
